//--- logic/msf_sfr_space.sv
// msf_sfr_space: special-function space, internal ram, pointers, status and ports
//
// Behaviour
// - Two 16-bit pointers; select bit 0 chooses.
// - Changing select leaves both pointers intact.
// - Pointer operations act on selected pointer.
// - Paged moves take high byte from page register.
// - Internal memory is 256 bytes, 8-bit address.
// - Upper half: direct hits registers, indirect hits ram.
// - Status bits 4:3 pick one of four banks.
// - Bytes 0x20-0x2f bit addressable; lower half shared.
// - Unimplemented registers: read zero, write ignored.
// - Registers at multiples of eight are bit addressable.
// - Stack starts 0x07, incremented before each push.
// - Hardware keeps parity flag from accumulator.
// - Status word flag layout as documented.
// - Pointer bytes separately writable at 0x82-0x85.
// - Program counter resets zero, advances per fetch.
// - Latch bit drives output pin high or low.
// - Direction bit one makes pin an output.
// - Port read returns real pin level; port 3 at 0xb0 has no pins here and reads back its stored latch.
module msf_sfr_space #(
	parameter int RAM_DEPTH = msf_pkg::RAM_BYTES
) (
	// clock, reset, enable
	input  wire logic                                i_mclk,
	input  wire logic                                i_resetn,
	input  wire logic                                i_ce,
	// memory and register requests
	input  wire msf_pkg::msf_req_t                   i_req,
	output logic                                     o_busy,
	output logic                                     o_rvalid,
	output logic [7:0]                               o_rdata,
	// paged external-data address
	output logic                                     o_xvalid,
	output logic [15:0]                              o_xaddr,
	// program counter
	input  wire logic                                i_pc_adv,
	input  wire logic                                i_pc_load,
	input  wire logic [15:0]                         i_pc_val,
	output logic [15:0]                              o_pc,
	// selected address pointer
	input  wire logic                                i_ptr_inc,
	input  wire logic                                i_ptr_load,
	input  wire logic [15:0]                         i_ptr_val,
	output logic [15:0]                              o_ptr,
	// accumulator, flags, stack
	input  wire logic                                i_acc_we,
	input  wire logic [7:0]                          i_acc_val,
	input  wire msf_pkg::msf_flags_t                 i_flags,
	output logic [7:0]                               o_acc,
	output logic [7:0]                               o_status,
	output logic [7:0]                               o_sp,
	// port pins
	input  wire logic [msf_pkg::NUM_PORTS-1:0][7:0]  i_pin,
	output logic [msf_pkg::NUM_PORTS-1:0][7:0]       o_pin_out,
	output logic [msf_pkg::NUM_PORTS-1:0][7:0]       o_pin_oe
);
	import msf_pkg::*;

	// state and storage
	msf_state_t st_q;
	msf_op_t    pend_op_q;
	logic       pend_sfr_q;
	logic [7:0] pend_addr_q;
	logic [2:0] pend_bit_q;
	logic       pend_val_q;
	logic [7:0] hold_q;
	logic [7:0] page_q;
	logic       rvalid_q;
	logic [7:0] rdata_q;
	logic       xvalid_q;
	logic [15:0] xaddr_q;
	logic [7:0] sp_q;
	logic [7:1] psw_q;
	logic       par_q;
	logic [7:0] acc_q;
	logic [7:0] acc_d;
	logic [15:0] pc_q;
	logic [15:0] pa_q;
	logic [15:0] pb_q;
	logic [15:0] pa_d;
	logic [15:0] pb_d;
	logic [7:0] dps_q;
	logic [7:0] dps_d;
	logic [15:0] ptr_q;
	logic [7:0] lat_q [NUM_PORTS];
	logic [7:0] dir_q [NUM_PORTS];
	logic [7:0] sfr_gen [128];

	// request decode
	msf_op_t    op;
	logic       take;
	logic [1:0] bank;
	logic       is_bit;
	logic       direct;
	logic       to_sfr;
	logic       sfr_we;
	logic       needs_wait;
	logic       rmw_wr;
	logic       ram_we;
	logic [7:0] byte_addr;
	logic [7:0] ram_addr;
	logic [7:0] ram_wd;
	logic [7:0] ram_rd;
	logic [7:0] sfr_view;
	logic [7:0] pin_view;
	logic       is_port;
	logic [7:0] sfr_rd;
	logic [7:0] sfr_wd;
	logic [7:0] src;

	assign op     = i_req.op;
	assign take   = i_req.valid && st_q == ST_IDLE;
	assign bank   = psw_q[PSW_BANK_HI:PSW_BANK_LO];
	assign is_bit = op == CMD_BIT_READ || op == CMD_BIT_WRITE;
	assign direct = (op == CMD_READ || op == CMD_WRITE) && !i_req.indirect && !i_req.rn;
	assign to_sfr = byte_addr[7] && (direct || is_bit);
	assign sfr_we = take && to_sfr && (op == CMD_WRITE || op == CMD_BIT_WRITE);

	// reads and ram bit writes need the memory's registered read cycle
	assign needs_wait = take && (op == CMD_READ || op == CMD_BIT_READ || op == CMD_POP
		|| op == CMD_XRI || (op == CMD_BIT_WRITE && !to_sfr));

	// byte address: banked register, bit row, or plain byte
	always_comb begin
		byte_addr = i_req.addr;
		if (is_bit) begin
			if (i_req.addr[7]) begin
				byte_addr = {i_req.addr[7:3], 3'h0};
			end else begin
				byte_addr = {BITRAM_ROW, i_req.addr[6:3]};
			end
		end else if (i_req.rn) begin
			byte_addr = {3'h0, bank, i_req.addr[2:0]};
		end
	end

	// ram address; indirect keeps all eight bits so 0x80+ lands in ram
	always_comb begin
		ram_addr = byte_addr;
		case (op)
			CMD_PUSH: ram_addr = sp_q + 8'h01;
			CMD_POP:  ram_addr = sp_q;
			CMD_XRI:  ram_addr = {3'h0, bank, 2'h0, i_req.addr[0]};
			default:  ;
		endcase
		if (st_q == ST_WAIT) begin
			ram_addr = pend_addr_q;
		end
	end

	assign rmw_wr = st_q == ST_WAIT && pend_op_q == CMD_BIT_WRITE;
	assign ram_we = rmw_wr || (take && (op == CMD_PUSH || (op == CMD_WRITE && !to_sfr)));

	// ram write data; bit writes merge into the byte just read
	always_comb begin
		ram_wd = i_req.wdata;
		if (rmw_wr) begin
			ram_wd = ram_rd;
			ram_wd[pend_bit_q] = pend_val_q;
		end
	end

	msf_ram #(
		.DEPTH   (RAM_DEPTH)
	) u_ram (
		.i_mclk  (i_mclk),
		.i_resetn(i_resetn),
		.i_ce    (i_ce),
		.i_we    (ram_we),
		.i_addr  (ram_addr),
		.i_wdata (ram_wd),
		.o_rdata (ram_rd)
	);

	// register view; ports show the latch here, the pins on a byte or bit read
	always_comb begin
		sfr_view = sfr_gen[byte_addr[6:0]];
		pin_view = 8'h00;
		is_port  = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (byte_addr == PORT_LATCH_OFF[p]) begin
				sfr_view = lat_q[p];
				pin_view = i_pin[p];
				is_port  = 1'b1;
			end
			if (byte_addr == PORT_DIR_OFF[p]) begin
				sfr_view = dir_q[p];
			end
		end
		case (byte_addr)
			OFF_STACK_POINTER:  sfr_view = sp_q;
			OFF_POINTER_A_LOW:  sfr_view = pa_q[7:0];
			OFF_POINTER_A_HIGH: sfr_view = pa_q[15:8];
			OFF_POINTER_B_LOW:  sfr_view = pb_q[7:0];
			OFF_POINTER_B_HIGH: sfr_view = pb_q[15:8];
			OFF_POINTER_SELECT: sfr_view = dps_q;
			OFF_PROGRAM_STATUS: sfr_view = {psw_q, par_q};
			OFF_ACCUMULATOR:    sfr_view = acc_q;
			default:            ;
		endcase
	end

	assign sfr_rd = is_port ? pin_view : sfr_view;

	// bit write: read-modify-write on the latch, never on the pins
	always_comb begin
		sfr_wd = i_req.wdata;
		if (is_bit) begin
			sfr_wd = sfr_view;
			sfr_wd[i_req.addr[2:0]] = i_req.bit_val;
		end
	end

	// plain registers; unimplemented slots read zero and ignore writes
	for (genvar g = 0; g < 128; g++) begin : g_sfr
		localparam logic [7:0] OFF = SFR_BASE + 8'(g);
		if (sfr_generic(OFF)) begin : g_impl
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn) begin
					sfr_gen[g] <= sfr_reset(OFF);
				end else if (i_ce && sfr_we && byte_addr == OFF) begin
					sfr_gen[g] <= sfr_wd;
				end
			end
		end else begin : g_none
			assign sfr_gen[g] = 8'h00;
		end
	end

	// port latch and direction per port
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		always_ff @(posedge i_mclk or negedge i_resetn) begin
			if (!i_resetn) begin
				lat_q[p] <= RST_PORT_LATCH;
				dir_q[p] <= RST_PORT_DIRECTION;
			end else if (i_ce && sfr_we) begin
				if (byte_addr == PORT_LATCH_OFF[p]) begin
					lat_q[p] <= sfr_wd;
				end
				if (byte_addr == PORT_DIR_OFF[p]) begin
					dir_q[p] <= sfr_wd;
				end
			end
		end
		assign o_pin_out[p] = lat_q[p];
		assign o_pin_oe[p]  = dir_q[p];
	end

	// stack pointer steps on push and pop; a register write at 0x81 loads it
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sp_q <= RST_STACK_POINTER;
		end else if (i_ce) begin
			if (take && op == CMD_PUSH) begin
				sp_q <= sp_q + 8'h01;
			end else if (take && op == CMD_POP) begin
				sp_q <= sp_q - 8'h01;
			end else if (sfr_we && byte_addr == OFF_STACK_POINTER) begin
				sp_q <= sfr_wd;
			end
		end
	end

	// status word; core flag updates win over a register write
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			psw_q <= RST_ZERO[7:1];
		end else if (i_ce) begin
			if (sfr_we && byte_addr == OFF_PROGRAM_STATUS) begin
				psw_q <= sfr_wd[7:1];
			end
			if (i_flags.we) begin
				psw_q[PSW_CARRY] <= i_flags.cy;
				psw_q[PSW_AUX]   <= i_flags.ac;
				psw_q[PSW_OVF]   <= i_flags.ov;
			end
		end
	end

	// accumulator; parity tracks the new value so it is never stale
	always_comb begin
		acc_d = acc_q;
		if (sfr_we && byte_addr == OFF_ACCUMULATOR) begin
			acc_d = sfr_wd;
		end
		if (i_acc_we) begin
			acc_d = i_acc_val;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_q <= RST_ZERO;
			par_q <= 1'b0;
		end else if (i_ce) begin
			acc_q <= acc_d;
			par_q <= ^acc_d;
		end
	end

	// program counter; a load beats an advance
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			pc_q <= RST_PROGRAM_CTR;
		end else if (i_ce) begin
			if (i_pc_load) begin
				pc_q <= i_pc_val;
			end else if (i_pc_adv) begin
				pc_q <= pc_q + 16'h0001;
			end
		end
	end

	// pointers; core operations use the select bit as it stood
	always_comb begin
		pa_d  = pa_q;
		pb_d  = pb_q;
		dps_d = dps_q;
		if (sfr_we) begin
			case (byte_addr)
				OFF_POINTER_A_LOW:  pa_d[7:0]  = sfr_wd;
				OFF_POINTER_A_HIGH: pa_d[15:8] = sfr_wd;
				OFF_POINTER_B_LOW:  pb_d[7:0]  = sfr_wd;
				OFF_POINTER_B_HIGH: pb_d[15:8] = sfr_wd;
				OFF_POINTER_SELECT: dps_d      = sfr_wd;
				default:            ;
			endcase
		end
		if (i_ptr_load || i_ptr_inc) begin
			if (dps_q[PTR_SEL_BIT]) begin
				pb_d = i_ptr_load ? i_ptr_val : pb_q + 16'h0001;
			end else begin
				pa_d = i_ptr_load ? i_ptr_val : pa_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			pa_q  <= {RST_ZERO, RST_ZERO};
			pb_q  <= {RST_ZERO, RST_ZERO};
			dps_q <= RST_ZERO;
			ptr_q <= {RST_ZERO, RST_ZERO};
		end else if (i_ce) begin
			pa_q  <= pa_d;
			pb_q  <= pb_d;
			dps_q <= dps_d;
			ptr_q <= dps_d[PTR_SEL_BIT] ? pb_d : pa_d;
		end
	end

	// request sequencer
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_q <= ST_IDLE;
		end else if (i_ce) begin
			st_q <= needs_wait ? ST_WAIT : ST_IDLE;
		end
	end

	// context of a request that waits for the ram
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_op_q   <= CMD_READ;
			pend_sfr_q  <= 1'b0;
			pend_addr_q <= 8'h00;
			pend_bit_q  <= 3'h0;
			pend_val_q  <= 1'b0;
			hold_q      <= 8'h00;
			page_q      <= 8'h00;
		end else if (i_ce && take) begin
			pend_op_q   <= op;
			pend_sfr_q  <= to_sfr;
			pend_addr_q <= ram_addr;
			pend_bit_q  <= i_req.addr[2:0];
			pend_val_q  <= i_req.bit_val;
			hold_q      <= sfr_rd;
			page_q      <= sfr_gen[OFF_XRAM_PAGE_HIGH[6:0]];
		end
	end

	assign src = pend_sfr_q ? hold_q : ram_rd;

	// answers, one cycle after the wait state
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 8'h00;
			xvalid_q <= 1'b0;
			xaddr_q  <= 16'h0000;
		end else if (i_ce) begin
			rvalid_q <= 1'b0;
			xvalid_q <= 1'b0;
			if (st_q == ST_WAIT) begin
				case (pend_op_q)
					CMD_READ, CMD_POP: begin
						rvalid_q <= 1'b1;
						rdata_q  <= src;
					end
					CMD_BIT_READ: begin
						rvalid_q <= 1'b1;
						rdata_q  <= {7'h00, src[pend_bit_q]};
					end
					CMD_XRI: begin
						xvalid_q <= 1'b1;
						xaddr_q  <= {page_q, ram_rd};
					end
					default: ;
				endcase
			end
		end
	end

	assign o_busy   = st_q[1];
	assign o_rvalid = rvalid_q;
	assign o_rdata  = rdata_q;
	assign o_xvalid = xvalid_q;
	assign o_xaddr  = xaddr_q;
	assign o_pc     = pc_q;
	assign o_ptr    = ptr_q;
	assign o_acc    = acc_q;
	assign o_status = {psw_q, par_q};
	assign o_sp     = sp_q;

	// checks
	AST_PTR_SEL: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		o_ptr == (dps_q[PTR_SEL_BIT] ? pb_q : pa_q))
		else $error("selected pointer output mismatch");

	AST_PTR_KEEP: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		i_ce && sfr_we && byte_addr == OFF_POINTER_SELECT && !i_ptr_load && !i_ptr_inc
		|=> $stable(pa_q) && $stable(pb_q))
		else $error("select write disturbed a pointer");

	AST_PTR_INC: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		i_ce && i_ptr_inc && !i_ptr_load && !sfr_we && dps_q[PTR_SEL_BIT]
		|=> pb_q == $past(pb_q) + 16'h0001 && $stable(pa_q))
		else $error("increment missed the selected pointer");

	AST_XRI_PAGE: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		i_ce && take && op == CMD_XRI ##1 i_ce
		|=> o_xvalid && o_xaddr[15:8] == $past(sfr_gen[OFF_XRAM_PAGE_HIGH[6:0]], 2))
		else $error("paged address high byte wrong");

	AST_BANK: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		take && i_req.rn && (op == CMD_READ || op == CMD_WRITE)
		|-> ram_addr == {3'h0, psw_q[PSW_BANK_HI:PSW_BANK_LO], i_req.addr[2:0]})
		else $error("register bank address wrong");

	AST_SP_RESET: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		$rose(i_resetn) |-> o_sp == RST_STACK_POINTER)
		else $error("stack pointer reset value wrong");

	AST_PUSH: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		i_ce && take && op == CMD_PUSH
		|-> ram_we && ram_addr == o_sp + 8'h01 ##1 o_sp == $past(o_sp) + 8'h01)
		else $error("push did not pre-increment");

	AST_PARITY: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		o_status[0] == ^o_acc)
		else $error("parity flag out of step");

	AST_PC: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		i_ce && i_pc_adv && !i_pc_load |=> o_pc == $past(o_pc) + 16'h0001)
		else $error("program counter did not advance");

	AST_PIN_READ: assert property (
		@(posedge i_mclk) disable iff (!i_resetn)
		i_ce && take && direct && op == CMD_READ && i_req.addr == OFF_PORT1_LATCH ##1 i_ce
		|=> o_rvalid && o_rdata == $past(i_pin[1], 2))
		else $error("port read did not return pin level");
endmodule

//--- pkg/msf_pkg.sv
// msf_pkg: special-function map, reset values, field positions and carrier types
package msf_pkg;
	// special-function offsets
	localparam logic [7:0] OFF_PORT0_LATCH            = 8'h80;
	localparam logic [7:0] OFF_STACK_POINTER          = 8'h81;
	localparam logic [7:0] OFF_POINTER_A_LOW          = 8'h82;
	localparam logic [7:0] OFF_POINTER_A_HIGH         = 8'h83;
	localparam logic [7:0] OFF_POINTER_B_LOW          = 8'h84;
	localparam logic [7:0] OFF_POINTER_B_HIGH         = 8'h85;
	localparam logic [7:0] OFF_POWER_AND_SERIAL_SPEED = 8'h87;
	localparam logic [7:0] OFF_TIMER_CONTROL          = 8'h88;
	localparam logic [7:0] OFF_TIMER_MODE             = 8'h89;
	localparam logic [7:0] OFF_TIMER0_LOW_BYTE        = 8'h8a;
	localparam logic [7:0] OFF_TIMER1_LOW_BYTE        = 8'h8b;
	localparam logic [7:0] OFF_TIMER0_HIGH_BYTE       = 8'h8c;
	localparam logic [7:0] OFF_TIMER1_HIGH_BYTE       = 8'h8d;
	localparam logic [7:0] OFF_MEMORY_STRETCH_CTRL    = 8'h8e;
	localparam logic [7:0] OFF_PORT1_LATCH            = 8'h90;
	localparam logic [7:0] OFF_PORT1_DIRECTION        = 8'h91;
	localparam logic [7:0] OFF_POINTER_SELECT         = 8'h92;
	localparam logic [7:0] OFF_SERIAL0_CONTROL        = 8'h98;
	localparam logic [7:0] OFF_SERIAL0_BUFFER         = 8'h99;
	localparam logic [7:0] OFF_INT_ENABLE_TWO         = 8'h9a;
	localparam logic [7:0] OFF_SERIAL1_CONTROL        = 8'h9b;
	localparam logic [7:0] OFF_SERIAL1_BUFFER         = 8'h9c;
	localparam logic [7:0] OFF_SERIAL1_RELOAD_LOW     = 8'h9d;
	localparam logic [7:0] OFF_PORT2_LATCH            = 8'ha0;
	localparam logic [7:0] OFF_PORT2_DIRECTION        = 8'ha1;
	localparam logic [7:0] OFF_PORT0_DIRECTION        = 8'ha2;
	localparam logic [7:0] OFF_INT_ENABLE_ZERO        = 8'ha8;
	localparam logic [7:0] OFF_INT_PRIORITY_ZERO      = 8'ha9;
	localparam logic [7:0] OFF_SERIAL0_RELOAD_LOW     = 8'haa;
	localparam logic [7:0] OFF_PORT3_LATCH            = 8'hb0;
	localparam logic [7:0] OFF_INT_ENABLE_ONE         = 8'hb8;
	localparam logic [7:0] OFF_INT_PRIORITY_ONE       = 8'hb9;
	localparam logic [7:0] OFF_SERIAL0_RELOAD_HIGH    = 8'hba;
	localparam logic [7:0] OFF_SERIAL1_RELOAD_HIGH    = 8'hbb;
	localparam logic [7:0] OFF_XRAM_PAGE_HIGH         = 8'hbf;
	localparam logic [7:0] OFF_INT_REQUEST_CTRL       = 8'hc0;
	localparam logic [7:0] OFF_EXT_INT_POLARITY       = 8'hc8;
	localparam logic [7:0] OFF_PROGRAM_STATUS         = 8'hd0;
	localparam logic [7:0] OFF_BAUD_SOURCE_CTRL       = 8'hd8;
	localparam logic [7:0] OFF_ACCUMULATOR            = 8'he0;
	localparam logic [7:0] OFF_MULTIPLY_AUX_REG       = 8'hf0;

	// reset values
	localparam logic [7:0]  RST_ZERO           = 8'h00;
	localparam logic [7:0]  RST_PORT_LATCH     = 8'hff;
	localparam logic [7:0]  RST_PORT_DIRECTION = 8'h00;
	localparam logic [7:0]  RST_STACK_POINTER  = 8'h07;
	localparam logic [7:0]  RST_STRETCH        = 8'h01;
	localparam logic [7:0]  RST_SER0_RELOAD_LO = 8'hd9;
	localparam logic [7:0]  RST_RELOAD_HIGH    = 8'h03;
	localparam logic [15:0] RST_PROGRAM_CTR    = 16'h0000;

	// status word fields and the pointer select bit
	localparam int PSW_CARRY   = 7;
	localparam int PSW_AUX     = 6;
	localparam int PSW_BANK_HI = 4;
	localparam int PSW_BANK_LO = 3;
	localparam int PSW_OVF     = 2;
	localparam int PTR_SEL_BIT = 0;

	// address space layout
	localparam logic [7:0] SFR_BASE   = 8'h80;
	localparam logic [3:0] BITRAM_ROW = 4'h2;
	localparam int         RAM_BYTES  = 256;
	localparam int         NUM_PORTS  = 3;
	localparam logic [NUM_PORTS-1:0][7:0] PORT_LATCH_OFF =
		{OFF_PORT2_LATCH, OFF_PORT1_LATCH, OFF_PORT0_LATCH};
	localparam logic [NUM_PORTS-1:0][7:0] PORT_DIR_OFF =
		{OFF_PORT2_DIRECTION, OFF_PORT1_DIRECTION, OFF_PORT0_DIRECTION};

	// request kinds from the core
	typedef enum logic [2:0] {
		CMD_READ      = 3'h0,
		CMD_WRITE     = 3'h1,
		CMD_BIT_READ  = 3'h2,
		CMD_BIT_WRITE = 3'h3,
		CMD_PUSH      = 3'h4,
		CMD_POP       = 3'h5,
		CMD_XRI       = 3'h6
	} msf_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} msf_state_t;

	typedef struct packed {
		logic       valid;
		msf_op_t    op;
		logic       indirect;
		logic       rn;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       bit_val;
	} msf_req_t;

	typedef struct packed {
		logic we;
		logic cy;
		logic ac;
		logic ov;
	} msf_flags_t;

	// plain storage registers; apart from the page register, no hardware behaviour behind them here
	function automatic logic sfr_generic(logic [7:0] off);
		case (off)
			OFF_POWER_AND_SERIAL_SPEED, OFF_TIMER_CONTROL, OFF_TIMER_MODE,
			OFF_TIMER0_LOW_BYTE, OFF_TIMER1_LOW_BYTE, OFF_TIMER0_HIGH_BYTE,
			OFF_TIMER1_HIGH_BYTE, OFF_MEMORY_STRETCH_CTRL, OFF_SERIAL0_CONTROL,
			OFF_SERIAL0_BUFFER, OFF_INT_ENABLE_TWO, OFF_SERIAL1_CONTROL,
			OFF_SERIAL1_BUFFER, OFF_SERIAL1_RELOAD_LOW, OFF_INT_ENABLE_ZERO,
			OFF_INT_PRIORITY_ZERO, OFF_SERIAL0_RELOAD_LOW, OFF_PORT3_LATCH,
			OFF_INT_ENABLE_ONE, OFF_INT_PRIORITY_ONE, OFF_SERIAL0_RELOAD_HIGH,
			OFF_SERIAL1_RELOAD_HIGH, OFF_XRAM_PAGE_HIGH, OFF_INT_REQUEST_CTRL,
			OFF_EXT_INT_POLARITY, OFF_BAUD_SOURCE_CTRL, OFF_MULTIPLY_AUX_REG:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] sfr_reset(logic [7:0] off);
		case (off)
			OFF_PORT3_LATCH:         return RST_PORT_LATCH;
			OFF_MEMORY_STRETCH_CTRL: return RST_STRETCH;
			OFF_SERIAL0_RELOAD_LOW:  return RST_SER0_RELOAD_LO;
			OFF_SERIAL0_RELOAD_HIGH,
			OFF_SERIAL1_RELOAD_HIGH: return RST_RELOAD_HIGH;
			default:                 return RST_ZERO;
		endcase
	endfunction
endpackage

//--- logic/msf_ram.sv
// msf_ram: internal data memory, single port, registered read
module msf_ram #(
	parameter int DEPTH = 256
) (
	// clock, reset, enable
	input  wire logic       i_mclk,
	input  wire logic       i_resetn,
	input  wire logic       i_ce,
	// access
	input  wire logic       i_we,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata
);
	logic [7:0] mem_q [DEPTH];
	logic [7:0] rd_q;

	// storage; no reset, contents are undefined after power-up
	always_ff @(posedge i_mclk) begin
		if (i_ce && i_we) begin
			mem_q[i_addr] <= i_wdata;
		end
	end

	// read-during-write returns the old byte
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_q <= 8'h00;
		end else if (i_ce) begin
			rd_q <= mem_q[i_addr];
		end
	end

	assign o_rdata = rd_q;
endmodule

//--- testbench/msf_board.sv
// msf_board: board-level drivers facing the three digital ports
module msf_board
	import msf_pkg::*;
(
	// design side
	input  wire logic [NUM_PORTS-1:0][7:0] i_pin_out,
	input  wire logic [NUM_PORTS-1:0][7:0] i_pin_oe,
	// board side
	input  wire logic [NUM_PORTS-1:0][7:0] i_ext,
	output logic      [NUM_PORTS-1:0][7:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// an enabled output wins; elsewhere the board's own level shows on the wire
	assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule

//--- testbench/msf_sfr_space_test.sv
// msf_sfr_space_test: register, pointer, stack, bank, paging and port checks
module msf_sfr_space_test;
	import msf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      i_mclk = 1'b0;
	logic                      i_resetn = 1'b0;
	logic                      ce = 1'b1;
	msf_req_t                  req = '0;
	logic                      pc_adv = 1'b0, pc_load = 1'b0, ptr_inc = 1'b0;
	logic                      ptr_load = 1'b0, acc_we = 1'b0;
	logic [15:0]               pc_val = 16'h0000, ptr_val = 16'h0000;
	logic [7:0]                acc_val = 8'h00;
	msf_flags_t                flags = '0;
	logic [NUM_PORTS-1:0][7:0] ext = 24'h3c_c3_a5;
	logic [NUM_PORTS-1:0][7:0] pin, pin_out, pin_oe;
	logic                      busy, rvalid, xvalid;
	logic [7:0]                rdata, acc, status, stack_ptr;
	logic [15:0]               xaddr, pc, ptr;
	int                        n_fail = 0;
	int                        checks_done = 0;
	// 250 MHz core clock
	always #2 i_mclk = ~i_mclk;
	msf_sfr_space msf_sfr_space_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce),
		.i_req(req), .o_busy(busy), .o_rvalid(rvalid), .o_rdata(rdata), .o_xvalid(xvalid),
		.o_xaddr(xaddr), .i_pc_adv(pc_adv), .i_pc_load(pc_load), .i_pc_val(pc_val), .o_pc(pc),
		.i_ptr_inc(ptr_inc), .i_ptr_load(ptr_load), .i_ptr_val(ptr_val), .o_ptr(ptr),
		.i_acc_we(acc_we), .i_acc_val(acc_val), .i_flags(flags), .o_acc(acc),
		.o_status(status), .o_sp(stack_ptr), .i_pin(pin), .o_pin_out(pin_out),
		.o_pin_oe(pin_oe));
	msf_board msf_board_inst (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext(ext), .o_pin(pin));
	task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// a fresh negedge first, so valid is never driven twice in one step
	task automatic issue(msf_op_t op, logic [7:0] a, logic [7:0] w, logic ind, logic rn);
		int k;
		@(negedge i_mclk);
		req = '{valid: 1'b1, op: op, indirect: ind, rn: rn, addr: a, wdata: w, bit_val: 1'b0};
		@(negedge i_mclk);
		req.valid = 1'b0;
		k = 0;
		while (busy === 1'b1 && k < 4) begin
			@(negedge i_mclk);
			k++;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] w, logic ind = 1'b0);
		issue(CMD_WRITE, a, w, ind, 1'b0);
	endtask
	task automatic rd(string what, logic [7:0] a, logic [7:0] exp, logic ind = 1'b0);
		issue(CMD_READ, a, 8'h00, ind, 1'b0);
		chk("rvalid", {15'h0000, rvalid}, 16'h0001);
		chk(what, {8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 400 cycles
	initial begin
		repeat (3000) @(posedge i_mclk);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(negedge i_mclk);
		i_resetn = 1'b1;
		chk("pc", pc, 16'h0000);
		chk("stack", {8'h00, stack_ptr}, 16'h0007);
		rd("stretch", OFF_MEMORY_STRETCH_CTRL, 8'h01);
		rd("reload", OFF_SERIAL0_RELOAD_LOW, 8'hd9);
		pc_adv = 1'b1;
		@(negedge i_mclk);
		pc_adv = 1'b0;
		chk("pc step", pc, 16'h0001);
		// enable low must freeze the counter even with an advance pending
		ce = 1'b0;
		pc_adv = 1'b1;
		@(negedge i_mclk);
		ce = 1'b1;
		pc_adv = 1'b0;
		chk("pc frozen", pc, 16'h0001);
		$display("test reset done");
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		wr(8'h84, 8'h78);
		wr(8'h85, 8'h56);
		chk("ptr a", ptr, 16'h1234);
		wr(8'h92, 8'h01);
		@(negedge i_mclk);
		chk("ptr b", ptr, 16'h5678);
		ptr_inc = 1'b1;
		@(negedge i_mclk);
		ptr_inc = 1'b0;
		chk("ptr inc", ptr, 16'h5679);
		ptr_val = 16'hbeef;
		ptr_load = 1'b1;
		@(negedge i_mclk);
		ptr_load = 1'b0;
		rd("ptr b hi", 8'h85, 8'hbe);
		rd("ptr a lo", 8'h82, 8'h34);
		$display("test pointers done");
		issue(CMD_PUSH, 8'h00, 8'ha5, 1'b0, 1'b0);
		chk("stack push", {8'h00, stack_ptr}, 16'h0008);
		rd("stacked", 8'h08, 8'ha5, 1'b1);
		issue(CMD_POP, 8'h00, 8'h00, 1'b0, 1'b0);
		chk("pop", {8'h00, rdata}, 16'h00a5);
		chk("stack pop", {8'h00, stack_ptr}, 16'h0007);
		wr(8'hd0, 8'h5e, 1'b1);
		rd("upper ram", 8'hd0, 8'h5e, 1'b1);
		rd("status direct", 8'hd0, 8'h00);
		wr(8'h86, 8'hff);
		rd("unimplemented", 8'h86, 8'h00);
		wr(8'hd0, 8'h10);
		issue(CMD_WRITE, 8'h01, 8'h44, 1'b0, 1'b1);
		rd("bank reg", 8'h11, 8'h44, 1'b1);
		wr(8'hbf, 8'hab);
		issue(CMD_XRI, 8'h01, 8'h00, 1'b0, 1'b0);
		chk("paged addr", xaddr, 16'hab44);
		chk("paged valid", {15'h0000, xvalid}, 16'h0001);
		$display("test memory done");
		acc_val = 8'h07;
		acc_we = 1'b1;
		flags = '{we: 1'b1, cy: 1'b1, ac: 1'b0, ov: 1'b1};
		@(negedge i_mclk);
		acc_we = 1'b0;
		flags = '0;
		@(negedge i_mclk);
		chk("status", {8'h00, status}, 16'h0095);
		chk("acc", {8'h00, acc}, 16'h0007);
		issue(CMD_BIT_READ, 8'hd7, 8'h00, 1'b0, 1'b0);
		chk("carry bit", {8'h00, rdata}, 16'h0001);
		$display("test status done");
		chk("latch reset", {8'h00, pin_out[0]}, 16'h00ff);
		wr(8'ha2, 8'h0f);
		wr(8'h80, 8'h5a);
		chk("port0_direction", {8'h00, pin_oe[0]}, 16'h000f);
		rd("port0 pins", 8'h80, 8'haa);
		wr(8'h91, 8'hf0);
		issue(CMD_BIT_WRITE, 8'h97, 8'h00, 1'b0, 1'b0);
		rd("port1 pins", 8'h90, 8'h73);
		wr(8'h20, 8'hff);
		issue(CMD_BIT_WRITE, 8'h03, 8'h00, 1'b0, 1'b0);
		rd("bit ram", 8'h20, 8'hf7, 1'b1);
		issue(CMD_BIT_READ, 8'h03, 8'h00, 1'b0, 1'b0);
		chk("bit read lo", {8'h00, rdata}, 16'h0000);
		issue(CMD_BIT_READ, 8'h02, 8'h00, 1'b0, 1'b0);
		chk("bit read hi", {8'h00, rdata}, 16'h0001);
		$display("test ports done");
		tally_and_finish();
	end
endmodule
